// ==== rtl/adc_channel_sequencer_control.sv ====
// Channel sequencer, range control and conversion timing for the input converter
// Notes on behaviour
// RQ1: Channel pointer covers 32 single-ended or 16 differential inputs.
// RQ2: Results are 16-bit two's complement in either polarity.
// RQ3: Two-bit gain field picks one of four ranges per polarity.
// RQ4: Polarity bit in analog configuration applies to every channel.
// RQ5: Gain and resolution do not depend on differential mode.
// RQ6: Low and high channel registers hold 5-bit channel numbers.
// RQ7: Writing either channel register loads the pointer with the low channel.
// RQ8: Each finished conversion advances the pointer by one.
// RQ9: After the high channel the pointer wraps to the low channel.
// RQ10: Range register keeps its value until rewritten.
// RQ11: Channel or range writes start a 10 us settling timer.
// RQ12: Status bit 6 reads one while settling, zero once settled.
// RQ13: Writing one to command bit 0 starts a conversion.
// RQ14: Software start is ignored while the converter interrupt enable is set.
// RQ15: With interrupt enable set, only timer or external triggers start.
// RQ16: Conversion takes 4 or 9 us, chosen by timing bit 3.
// RQ17: Status bit 7 reads one while converting, zero when data ready.
// RQ18: Result enters the buffer low byte first, read at offsets 0 and 1.
// RQ19: Acquisition reset clears channels and range, configuration becomes 0x04.
// RQ20: Settling uses a restartable cycle counter; busy rises on acceptance.
module adc_channel_sequencer_control
    import adc_seq_pkg::*;
(
    input  wire logic                CORE_CLK_IN,
    input  wire logic                RST_B_IN,
    input  wire adc_seq_pkg::io_req_t IO_REQ_IN,
    input  wire logic                DAQ_RESET_IN,
    input  wire logic                CONV_IRQ_EN_IN,
    input  wire logic                TIMER_TRIG_IN,
    input  wire logic                EXT_TRIG_IN,
    input  wire logic [15:0]         ADC_RESULT_IN,
    output logic [7:0]               RD_DATA_OUT,
    output logic [7:0]               ANALOG_CFG_OUT,
    output logic                     UNIPOLAR_OUT,
    output logic                     DIFF_MODE_OUT,
    output logic [1:0]               GAIN_OUT,
    output logic [4:0]               CHANNEL_OUT,
    output logic                     CONV_START_OUT,
    output logic                     CONV_BUSY_OUT,
    output logic                     SETTLING_OUT,
    output logic                     SAMPLE_READY_OUT
);
    // The flag reads counter != 0, so the load is the full count for a full 10 us
    localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE_CYC);
    localparam logic [CNT_W-1:0] FAST_LOAD   = CNT_W'(CONV_FAST_CYC - 1);
    localparam logic [CNT_W-1:0] SLOW_LOAD   = CNT_W'(CONV_SLOW_CYC - 1);
    localparam int FAST_LAST = CONV_FAST_CYC - 1;

    logic [7:0]       cfg_q;
    logic [4:0]       low_q;
    logic [4:0]       high_q;
    logic [1:0]       gain_q;
    logic [7:0]       timing_q;
    logic [4:0]       ptr_q;
    logic [CNT_W-1:0] settle_cnt_q;
    logic [CNT_W-1:0] conv_cnt_q;
    logic             conv_slow_q;
    conv_state_t      state_q;
    logic             ext_lvl;
    logic             ext_prev_q;
    logic             ext_rise;
    logic             wr_low;
    logic             wr_high;
    logic             wr_range;
    logic             sw_start;
    logic             trig;
    logic             accept;
    logic             done;
    logic [15:0]      sample;
    logic [7:0]       buf_lo;
    logic [7:0]       buf_hi;
    logic [7:0]       rd_d;

    function automatic logic hit(input io_req_t r, input logic [3:0] ofs);
        hit = r.wr && (r.addr == ofs);
    endfunction : hit

    pin_sync3 u_ext_sync (
        .clk_in    (CORE_CLK_IN),
        .rst_b_in  (RST_B_IN),
        .pin_in    (EXT_TRIG_IN),
        .level_out (ext_lvl)
    );

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_B_IN) begin
            ext_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= ext_lvl;
        end
    end

    assign ext_rise = ext_lvl && !ext_prev_q;
    assign wr_low   = hit(IO_REQ_IN, OFS_LOW_CHAN);
    assign wr_high  = hit(IO_REQ_IN, OFS_HIGH_CHAN);
    assign wr_range = hit(IO_REQ_IN, OFS_RANGE_STAT);
    assign sw_start = hit(IO_REQ_IN, OFS_COMMAND) && IO_REQ_IN.wdata[BIT_CMD_START];

    // Software start only with the enable clear; hardware triggers only with it set
    assign trig   = CONV_IRQ_EN_IN ? (TIMER_TRIG_IN || ext_rise) : sw_start; // RQ13 RQ14 RQ15
    assign accept = trig && (state_q == CONV_IDLE);
    assign done   = (state_q == CONV_RUN) && (conv_cnt_q == '0);

    // Configuration registers
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_B_IN || DAQ_RESET_IN) begin
            cfg_q    <= ANALOG_CFG_RST; // RQ19
            low_q    <= CHAN_RST;
            high_q   <= CHAN_RST;
            gain_q   <= GAIN_RST;
            timing_q <= TIMING_RST;
        end else begin
            if (hit(IO_REQ_IN, OFS_ANALOG_CFG)) begin
                cfg_q <= IO_REQ_IN.wdata; // RQ4
            end
            if (wr_low) begin
                low_q <= IO_REQ_IN.wdata[4:0]; // RQ6
            end
            if (wr_high) begin
                high_q <= IO_REQ_IN.wdata[4:0]; // RQ6
            end
            if (wr_range) begin
                gain_q <= IO_REQ_IN.wdata[1:0]; // RQ10
            end
            if (hit(IO_REQ_IN, OFS_CONV_TIMING)) begin
                timing_q <= IO_REQ_IN.wdata;
            end
        end
    end

    // Current channel pointer; a register write overrides an advance in the same cycle
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_B_IN || DAQ_RESET_IN) begin
            ptr_q <= CHAN_RST;
        end else if (wr_low) begin
            ptr_q <= IO_REQ_IN.wdata[4:0]; // RQ7
        end else if (wr_high) begin
            ptr_q <= low_q; // RQ7
        end else if (done) begin
            if (ptr_q == high_q) begin
                ptr_q <= low_q; // RQ9
            end else begin
                ptr_q <= ptr_q + 5'h01; // RQ8
            end
        end
    end

    // Settling timer restarts on every qualifying write
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_B_IN) begin
            settle_cnt_q <= '0;
        end else if (wr_low || wr_high || wr_range) begin
            settle_cnt_q <= SETTLE_LOAD; // RQ11 RQ20
        end else if (settle_cnt_q != '0) begin
            settle_cnt_q <= settle_cnt_q - CNT_W'(1);
        end
    end

    // A write during the last cycle still shows settling without a gap
    assign SETTLING_OUT = (settle_cnt_q != '0); // RQ12

    // Conversion sequencer; the duration is frozen at acceptance
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_B_IN) begin
            state_q     <= CONV_IDLE;
            conv_cnt_q  <= '0;
            conv_slow_q <= 1'b0;
        end else begin
            case (state_q)
                CONV_IDLE: begin
                    if (accept) begin
                        state_q     <= CONV_RUN; // RQ20
                        conv_slow_q <= timing_q[BIT_TIMING_SLOW];
                        conv_cnt_q  <= timing_q[BIT_TIMING_SLOW] ? SLOW_LOAD : FAST_LOAD; // RQ16
                    end
                end
                CONV_RUN: begin
                    if (done) begin
                        state_q <= CONV_IDLE;
                    end else begin
                        conv_cnt_q <= conv_cnt_q - CNT_W'(1);
                    end
                end
                default: begin
                    state_q <= CONV_IDLE;
                end
            endcase
        end
    end

    assign CONV_BUSY_OUT = (state_q == CONV_RUN); // RQ17

    // Busy length of the current conversion, kept only for the checks below
    logic [CNT_W-1:0] busy_len_q;

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_B_IN || accept) begin
            busy_len_q <= '0;
        end else if (CONV_BUSY_OUT) begin
            busy_len_q <= busy_len_q + CNT_W'(1);
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_B_IN) begin
            CONV_START_OUT <= 1'b0;
        end else begin
            CONV_START_OUT <= accept;
        end
    end

    // Unipolar converter codes are offset binary; flipping the sign bit yields two's complement
    assign sample = cfg_q[BIT_CFG_UNIPOLAR] ? {~ADC_RESULT_IN[15], ADC_RESULT_IN[14:0]}
                                            : ADC_RESULT_IN; // RQ2

    sample_byte_buffer u_buf (
        .clk_in    (CORE_CLK_IN),
        .rst_b_in  (RST_B_IN),
        .flush_in  (DAQ_RESET_IN),
        .push_in   (done),
        .word_in   (sample),
        .pop_lo_in (IO_REQ_IN.rd && IO_REQ_IN.addr == OFS_SAMPLE_LO),
        .pop_hi_in (IO_REQ_IN.rd && IO_REQ_IN.addr == OFS_SAMPLE_HI),
        .lo_out    (buf_lo),
        .hi_out    (buf_hi),
        .ready_out (SAMPLE_READY_OUT)
    ); // RQ18

    // Front-end steering; the top channel bit is dropped for differential pairs
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_B_IN) begin
            CHANNEL_OUT <= CHAN_RST;
        end else if (cfg_q[BIT_CFG_DIFF]) begin
            CHANNEL_OUT <= {1'b0, ptr_q[3:0]}; // RQ1
        end else begin
            CHANNEL_OUT <= ptr_q; // RQ1
        end
    end

    assign ANALOG_CFG_OUT = cfg_q;
    assign UNIPOLAR_OUT   = cfg_q[BIT_CFG_UNIPOLAR]; // RQ4
    assign DIFF_MODE_OUT  = cfg_q[BIT_CFG_DIFF];
    assign GAIN_OUT       = gain_q; // RQ3 RQ5

    // Read decode; offset 1 reads the high sample byte, not the configuration
    always_comb begin
        rd_d = 8'h00;
        case (IO_REQ_IN.addr)
            OFS_SAMPLE_LO:   rd_d = buf_lo;
            OFS_SAMPLE_HI:   rd_d = buf_hi;
            OFS_LOW_CHAN:    rd_d = {3'h0, low_q};
            OFS_HIGH_CHAN:   rd_d = {3'h0, high_q};
            OFS_RANGE_STAT:  rd_d = {CONV_BUSY_OUT, SETTLING_OUT, 4'h0, gain_q}; // RQ12 RQ17
            OFS_CONV_TIMING: rd_d = timing_q;
            default:         rd_d = 8'h00;
        endcase
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_B_IN) begin
            RD_DATA_OUT <= 8'h00;
        end else if (IO_REQ_IN.rd) begin
            RD_DATA_OUT <= rd_d;
        end
    end

    // Checks
    busy_on_accept_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) // RQ20
        accept |=> CONV_BUSY_OUT && CONV_START_OUT)
        else $error("busy did not rise after an accepted trigger");

    sw_start_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) // RQ13
        sw_start && !CONV_IRQ_EN_IN && !CONV_BUSY_OUT |=> CONV_BUSY_OUT)
        else $error("software start was not taken");

    sw_blocked_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) // RQ14
        sw_start && CONV_IRQ_EN_IN && !TIMER_TRIG_IN && !ext_rise && !CONV_BUSY_OUT |=> !CONV_BUSY_OUT)
        else $error("software start honoured with interrupt enable set");

    hw_blocked_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) // RQ15
        (TIMER_TRIG_IN || ext_rise) && !CONV_IRQ_EN_IN && !sw_start && !CONV_BUSY_OUT |=> !CONV_BUSY_OUT)
        else $error("hardware trigger taken with interrupt enable clear");

    fast_conv_len_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) // RQ16
        $rose(CONV_BUSY_OUT) && !conv_slow_q |-> ##[FAST_LAST:FAST_LAST] CONV_BUSY_OUT ##1 !CONV_BUSY_OUT)
        else $error("fast conversion length wrong");

    slow_conv_load_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) // RQ16
        $rose(CONV_BUSY_OUT) && conv_slow_q |-> conv_cnt_q == SLOW_LOAD)
        else $error("slow conversion length wrong");

    conv_len_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) // RQ16
        $fell(CONV_BUSY_OUT) |-> busy_len_q == (conv_slow_q ? CNT_W'(CONV_SLOW_CYC) : CNT_W'(CONV_FAST_CYC)))
        else $error("conversion busy length wrong");

    start_pulse_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) // RQ20
        CONV_START_OUT |=> !CONV_START_OUT)
        else $error("start pulse longer than one cycle");

    chan_load_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) // RQ7
        (wr_low || wr_high) && !DAQ_RESET_IN |=> ptr_q == low_q)
        else $error("channel write did not reload pointer");

    chan_advance_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) // RQ8
        done && ptr_q != high_q && !wr_low && !wr_high && !DAQ_RESET_IN |=> ptr_q == $past(ptr_q) + 5'h01)
        else $error("pointer did not advance");

    chan_wrap_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) // RQ9
        done && ptr_q == high_q && !wr_low && !wr_high && !DAQ_RESET_IN |=> ptr_q == $past(low_q))
        else $error("pointer did not wrap");

    settle_hold_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) // RQ11
        wr_range |=> SETTLING_OUT [*8])
        else $error("settling flag dropped early");

    settle_end_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) // RQ12
        settle_cnt_q == CNT_W'(1) && !wr_low && !wr_high && !wr_range |=> !SETTLING_OUT)
        else $error("settling flag stuck");

    byte_order_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) // RQ18
        done && !DAQ_RESET_IN |=> buf_lo == $past(sample[7:0]) && buf_hi == $past(sample[15:8]) && SAMPLE_READY_OUT)
        else $error("sample bytes misplaced");

    unipolar_code_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) // RQ2
        done && UNIPOLAR_OUT |-> sample[15] == !ADC_RESULT_IN[15]
            && sample[14:0] == ADC_RESULT_IN[14:0])
        else $error("unipolar code not two's complement");

    daq_reset_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) // RQ19
        DAQ_RESET_IN |=> cfg_q == ANALOG_CFG_RST && low_q == CHAN_RST && high_q == CHAN_RST && gain_q == GAIN_RST)
        else $error("acquisition reset values wrong");

    diff_chan_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) // RQ1
        DIFF_MODE_OUT && $stable(DIFF_MODE_OUT) |=> !CHANNEL_OUT[4])
        else $error("differential channel above 15");

    sw_conv_c: cover property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
        sw_start && !CONV_IRQ_EN_IN ##1 CONV_BUSY_OUT);
    wrap_c: cover property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
        done && ptr_q == high_q && low_q != high_q);
    ext_conv_c: cover property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
        ext_rise && CONV_IRQ_EN_IN && !CONV_BUSY_OUT);
    tmr_conv_c: cover property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
        TIMER_TRIG_IN && CONV_IRQ_EN_IN && !CONV_BUSY_OUT);

endmodule : adc_channel_sequencer_control

// ==== rtl/adc_seq_pkg.sv ====
// Shared constants and types for the converter channel sequencer
package adc_seq_pkg;

    // Register offsets on the byte-wide port
    localparam logic [3:0] OFS_SAMPLE_LO   = 4'h0;
    localparam logic [3:0] OFS_SAMPLE_HI   = 4'h1;
    localparam logic [3:0] OFS_ANALOG_CFG  = 4'h1;
    localparam logic [3:0] OFS_LOW_CHAN    = 4'h2;
    localparam logic [3:0] OFS_HIGH_CHAN   = 4'h3;
    localparam logic [3:0] OFS_RANGE_STAT  = 4'h4;
    localparam logic [3:0] OFS_CONV_TIMING = 4'hC;
    localparam logic [3:0] OFS_COMMAND     = 4'hF;

    // Field positions
    localparam int BIT_CFG_UNIPOLAR = 0;
    localparam int BIT_CFG_DIFF     = 1;
    localparam int BIT_STAT_SETTLE  = 6;
    localparam int BIT_STAT_BUSY    = 7;
    localparam int BIT_TIMING_SLOW  = 3;
    localparam int BIT_CMD_START    = 0;

    // Reset values
    localparam logic [7:0] ANALOG_CFG_RST = 8'h04;
    localparam logic [4:0] CHAN_RST       = 5'h00;
    localparam logic [1:0] GAIN_RST       = 2'h0;
    localparam logic [7:0] TIMING_RST     = 8'h00;

    // Timing, in nanoseconds, and derived cycle counts
    localparam int CLK_PERIOD_NS = 8;
    localparam int SETTLE_NS     = 10000;
    localparam int CONV_FAST_NS  = 4000;
    localparam int CONV_SLOW_NS  = 9000;
    localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_FAST_CYC = CONV_FAST_NS / CLK_PERIOD_NS;
    localparam int CONV_SLOW_CYC = CONV_SLOW_NS / CLK_PERIOD_NS;
    localparam int CNT_W         = 11;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } io_req_t;

    typedef enum logic [0:0] {
        CONV_IDLE = 1'b0,
        CONV_RUN  = 1'b1
    } conv_state_t;

endpackage : adc_seq_pkg

// ==== rtl/pin_sync3.sv ====
// Three-stage synchroniser for a pin level
module pin_sync3 (
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    input  wire logic pin_in,
    output logic      level_out
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change counts only once the last two stages agree
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            level_out <= 1'b0;
        end else if (s2_q == s3_q) begin
            level_out <= s3_q;
        end
    end
endmodule : pin_sync3

// ==== rtl/sample_byte_buffer.sv ====
// Byte-wide holding buffer for one converted sample
module sample_byte_buffer (
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        flush_in,
    input  wire logic        push_in,
    input  wire logic [15:0] word_in,
    input  wire logic        pop_lo_in,
    input  wire logic        pop_hi_in,
    output logic [7:0]       lo_out,
    output logic [7:0]       hi_out,
    output logic             ready_out
);
    logic [7:0] byte_q [2];
    logic [1:0] full_q;

    assign lo_out    = byte_q[0];
    assign hi_out    = byte_q[1];
    assign ready_out = full_q[0];

    // Low byte goes to entry 0 and high byte to entry 1, both on the same push
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            byte_q[0] <= 8'h00;
            byte_q[1] <= 8'h00;
        end else if (push_in) begin
            byte_q[0] <= word_in[7:0];
            byte_q[1] <= word_in[15:8];
        end
    end

    // Each byte is read once; a push wins over a pop in the same cycle
    always_ff @(posedge clk_in) begin
        if (!rst_b_in || flush_in) begin
            full_q <= 2'h0;
        end else if (push_in) begin
            full_q <= 2'h3;
        end else begin
            if (pop_lo_in) begin
                full_q[0] <= 1'b0;
            end
            if (pop_hi_in) begin
                full_q[1] <= 1'b0;
            end
        end
    end
endmodule : sample_byte_buffer

// ==== sim/adc_front_model.sv ====
// Converter front-end model returning a channel-tagged raw code
module adc_front_model (
    input  wire logic        clk_in,
    input  wire logic        busy_in,
    input  wire logic [4:0]  chan_in,
    output logic      [15:0] code_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial code_out = 16'h0000;
    // Code holds only while converting; it toggles otherwise so a mistimed sample shows
    always @(posedge clk_in) begin
        if (busy_in) code_out <= {3'h5, chan_in, 8'h3C};
        else code_out <= ~code_out;
    end
endmodule : adc_front_model

// ==== sim/tb_top.sv ====
// Self-checking bench for the converter channel sequencer
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_seq_pkg::*;

    logic        clk;
    logic        rst_b;
    logic        daq_rst;
    logic        irq_en;
    logic        tmr_trig;
    logic        ext_trig;
    io_req_t     req;
    logic [15:0] code;
    logic [7:0]  rd_data;
    logic [7:0]  cfg;
    logic        uni;
    logic        diff;
    logic [1:0]  gain;
    logic [4:0]  chan;
    logic        start;
    logic        busy;
    logic        settle;
    logic        ready;
    int          n_fail;
    int          check_count;

    adc_channel_sequencer_control i_adc_channel_sequencer_control (
        .CORE_CLK_IN(clk), .RST_B_IN(rst_b), .IO_REQ_IN(req), .DAQ_RESET_IN(daq_rst),
        .CONV_IRQ_EN_IN(irq_en), .TIMER_TRIG_IN(tmr_trig), .EXT_TRIG_IN(ext_trig),
        .ADC_RESULT_IN(code), .RD_DATA_OUT(rd_data), .ANALOG_CFG_OUT(cfg),
        .UNIPOLAR_OUT(uni), .DIFF_MODE_OUT(diff), .GAIN_OUT(gain), .CHANNEL_OUT(chan),
        .CONV_START_OUT(start), .CONV_BUSY_OUT(busy), .SETTLING_OUT(settle),
        .SAMPLE_READY_OUT(ready));

    adc_front_model i_adc_front_model (.clk_in(clk), .busy_in(busy), .chan_in(chan), .code_out(code));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        req = '0;
    endtask : wr_reg

    // Read data is taken a cycle late; it stands until the next read anyway
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(negedge clk);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk);
        req = '0;
        @(negedge clk);
        check(rd_data, exp);
    endtask : rd_chk

    task automatic wait_settle();
        for (int i = 0; i < 2000 && settle !== 1'b0; i++) @(negedge clk);
    endtask : wait_settle

    // Waits for a conversion, measures it and reads the sample back in byte order
    task automatic run_conv(input int ncyc, input logic [4:0] ch, input logic flip);
        int n;
        n = 0;
        for (int i = 0; i < 20 && busy !== 1'b1; i++) @(negedge clk);
        check(start, 1'b1);
        check(chan, ch);
        while (busy === 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        check(n, ncyc);
        @(negedge clk);
        check(ready, 1'b1);
        rd_chk(OFS_SAMPLE_LO, 8'h3C);
        check(ready, 1'b0);
        rd_chk(OFS_SAMPLE_HI, {3'h5, ch} ^ {flip, 7'h00});
    endtask : run_conv

    task automatic t_reset();
        check(cfg, ANALOG_CFG_RST);
        check({uni, diff, gain, chan}, 16'h0000);
        rd_chk(OFS_RANGE_STAT, 8'h00);
        rd_chk(4'h5, 8'h00);
    endtask : t_reset

    task automatic t_settle();
        int n;
        wr_reg(OFS_RANGE_STAT, 8'hFD);
        n = 0;
        while (settle === 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        check(n, SETTLE_CYC);
        rd_chk(OFS_RANGE_STAT, 8'h01);
        check(gain, 2'h1);
        wr_reg(OFS_HIGH_CHAN, 8'h05);
        rd_chk(OFS_RANGE_STAT, 8'h41);
        wr_reg(OFS_LOW_CHAN, 8'h03);
        n = 0;
        while (settle === 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        check(n, SETTLE_CYC);
        check(chan, 5'h03);
        rd_chk(OFS_LOW_CHAN, 8'h03);
    endtask : t_settle

    task automatic t_seq();
        wr_reg(OFS_LOW_CHAN, 8'h00);
        wr_reg(OFS_HIGH_CHAN, 8'h02);
        wait_settle();
        for (int i = 0; i < 4; i++) begin
            wr_reg(OFS_COMMAND, 8'h01);
            run_conv(CONV_FAST_CYC, 5'(i % 3), 1'b0);
        end
    endtask : t_seq

    task automatic t_uni_diff();
        wr_reg(OFS_ANALOG_CFG, 8'h03);
        wr_reg(OFS_LOW_CHAN, 8'hF2);
        wr_reg(OFS_HIGH_CHAN, 8'h12);
        check({uni, diff}, 2'h3);
        wait_settle();
        wr_reg(OFS_COMMAND, 8'h01);
        run_conv(CONV_FAST_CYC, 5'h02, 1'b1);
        check(gain, 2'h1);
    endtask : t_uni_diff

    task automatic t_irq_slow();
        wr_reg(OFS_CONV_TIMING, 8'h08);
        rd_chk(OFS_CONV_TIMING, 8'h08);
        irq_en = 1'b1;
        wr_reg(OFS_COMMAND, 8'h01);
        repeat (20) @(negedge clk);
        check(busy, 1'b0);
        tmr_trig = 1'b1;
        @(negedge clk);
        tmr_trig = 1'b0;
        run_conv(CONV_SLOW_CYC, 5'h02, 1'b1);
        ext_trig = 1'b1;
        run_conv(CONV_SLOW_CYC, 5'h02, 1'b1);
        ext_trig = 1'b0;
        irq_en = 1'b0;
        tmr_trig = 1'b1;
        @(negedge clk);
        tmr_trig = 1'b0;
        repeat (4) @(negedge clk);
        check(busy, 1'b0);
    endtask : t_irq_slow

    task automatic t_daq_reset();
        @(negedge clk);
        daq_rst = 1'b1;
        @(negedge clk);
        daq_rst = 1'b0;
        repeat (2) @(negedge clk);
        check(cfg, 8'h04);
        check({gain, chan}, 16'h0000);
        rd_chk(OFS_CONV_TIMING, 8'h00);
        rd_chk(OFS_HIGH_CHAN, 8'h00);
    endtask : t_daq_reset

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Whole run is roughly 10k cycles; the limit leaves wide margin
    initial begin
        #400us;
        n_fail++;
        close_out();
    end

    initial begin
        n_fail = 0;
        check_count = 0;
        rst_b = 1'b0;
        daq_rst = 1'b0;
        irq_en = 1'b0;
        tmr_trig = 1'b0;
        ext_trig = 1'b0;
        req = '0;
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        t_reset();
        t_settle();
        t_seq();
        t_uni_diff();
        t_irq_slow();
        t_daq_reset();
        close_out();
    end
endmodule : tb_top
